// file: src/wake_bus_pkg.sv
// Purpose: Shared constants for the wake and bus mode control block.
// Assumes: 40 MHz ref_clk, register frames arrive over the serial port.
// Notes:   Times are kept in their own unit, cycle counts derive from them.
// Overview of operation
// - Device never changes the top bit of the CAN mode field.
// - Sleep entry with CAN x11 and no system error sets x01.
// - CAN x10 goes wake capable on Sleep, stays receive only on Stop.
// - Wake capable or off CAN mode stays unchanged on Sleep or Stop.
// - Fail-Safe entry forces the bus mode low byte to 0000 1x01.
// - Software development mode resets CAN to 001 and LIN to 11.
// - Bit 15 picks pin 2 role, reachable only in bank 2.
// - Filter 000 is static 16us, 001 static 64us, 101-111 reserved.
// - Filter 010 and 011 are cyclic 16us at timer 1 or 2 end.
// - Filter 100 uses 80us settle then 16us, needs input 4 as sync.
// - Pull field: none, pull-down, pull-up, automatic switching.
// - Enable field: 00 and 11 off, 01 on, 10 sync on input 4.
// - Sync function is configurable only with bank 4 selected.
// - Reserved wake control bits ignore writes and read zero.
// - Fail-Safe entry sets enable 01 except pin 2 fail output, sync.
// - In Fail-Safe the filter field is ignored, static 16us used.
// - CAN codes: 000 off, 001 wake, 010 receive, 011 normal, 100 off.
// - LIN codes: 00 off, 01 wake, 10 receive, 11 normal.

package wake_bus_pkg;

  // ---------------------------------------------------------------
  // Register map and field positions
  // ---------------------------------------------------------------
  localparam logic [6:0] BUS_CTRL_ADDR  = 7'h04;
  localparam logic [6:0] WAKE_CTRL_ADDR = 7'h05;
  localparam int ROLE_POS  = 15;
  localparam int FILT_LSB  = 11;
  localparam int PUPD_LSB  = 9;
  localparam int EN_LSB    = 5;
  localparam int LINC_LSB  = 5;
  localparam int LIN_LSB   = 3;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CAN_OFF   = 3'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RX   = 2'h2;
  localparam logic [1:0] MODE_NORM = 2'h3;
  localparam logic [2:0] FILT_16   = 3'h0;
  localparam logic [2:0] FILT_SYNC = 3'h4;
  localparam logic [1:0] EN_ON     = 2'h1;
  localparam logic [1:0] EN_SYNC   = 2'h2;
  localparam logic [2:0] BANK_WK2  = 3'h1;
  localparam logic [2:0] BANK_WK4  = 3'h3;
  localparam logic [1:0] PUPD_RST  = 2'h0;
  localparam logic [1:0] EN_RST    = 2'h1;
  localparam logic [2:0] CAN_DEV   = 3'h1;
  localparam logic [1:0] LIN_DEV   = 2'h3;
  localparam logic [2:0] BOOT_DONE = 3'h5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 25;
  localparam int FRAME_BITS  = 32;
  localparam int FILT16_US   = 16;
  localparam int FILT64_US   = 64;
  localparam int SETTLE_US   = 80;
  localparam int FILT16_CYC  = (FILT16_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int FILT64_CYC  = (FILT64_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC  = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Codes 101 to 111 of the filter field are reserved
  function automatic logic filt_reserved(input logic [2:0] code);
    return code > FILT_SYNC;
  endfunction

endpackage

// file: src/pin_sync.sv
// Purpose: Three stage synchroniser with agreement filter for pins.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   Level follows stage two only once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Pins and clean levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;
  logic [WIDTH-1:0] nxt_lvl;

  // Agreement filter, stage one is never looked at here
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
    end
  end

  // Pin chain, idles at ones so select pins start inactive
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= '1;
      s2_ff  <= '1;
      s3_ff  <= '1;
      lvl_ff <= '1;
    end else begin
      s1_ff  <= pin_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
endmodule // pin_sync

// file: src/spi_frame.sv
// Purpose: Serial frame engine, 32 bits, MSB first, mode 0.
// Assumes: Clean levels from pin_sync; sck far slower than ref_clk.
// Notes:   Reply carries the register addressed by the previous frame.
`timescale 1ns/1ps
module spi_frame (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Clean pin levels
  input  wire logic        csn_lvl,
  input  wire logic        sck_lvl,
  input  wire logic        sdi_lvl,
  // Register side
  input  wire logic [15:0] rd_data,
  output logic             done,
  output logic [31:0]      frame,
  // Serial out
  output logic             sdo,
  output logic             sdo_oe
);
  logic [31:0] in_ff, nxt_in, out_ff, nxt_out;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic        csn_ff, sck_ff, done_ff, nxt_done;
  logic        oe_ff, nxt_oe;

  // Edge detection on the filtered levels only
  always_comb begin
    nxt_in   = in_ff;
    nxt_out  = out_ff;
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    nxt_oe   = !csn_lvl; // Own flop, so the enable pin carries no inverter
    if (csn_ff && !csn_lvl) begin
      nxt_cnt = 6'h00;
      nxt_out = {16'h0000, rd_data};
    end else if (!csn_lvl && sck_lvl && !sck_ff) begin
      nxt_in  = {in_ff[30:0], sdi_lvl};
      nxt_cnt = cnt_ff + 6'h01;
    end else if (!csn_lvl && !sck_lvl && sck_ff) begin
      nxt_out = {out_ff[30:0], 1'b0};
    end
    // Short or long frames are dropped whole, except lengths where the 6-bit count wraps to 32
    if (!csn_ff && csn_lvl && cnt_ff == 6'(wake_bus_pkg::FRAME_BITS)) begin
      nxt_done = 1'b1;
    end
  end

  // State registers, nothing computed here
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oe_ff   <= 1'b0;
      in_ff   <= 32'h00000000;
      out_ff  <= 32'h00000000;
      cnt_ff  <= 6'h00;
      csn_ff  <= 1'b1;
      sck_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      oe_ff   <= nxt_oe;
      in_ff   <= nxt_in;
      out_ff  <= nxt_out;
      cnt_ff  <= nxt_cnt;
      csn_ff  <= csn_lvl;
      sck_ff  <= sck_lvl;
      done_ff <= nxt_done;
    end
  end

  assign done   = done_ff;
  assign frame  = in_ff;
  assign sdo    = out_ff[31];
  assign sdo_oe = oe_ff;
endmodule // spi_frame

// file: src/wake_bus_ctrl.sv
// Purpose: Wake input control and bus mode registers with device updates.
// Assumes: Mode entry pulses come from the device mode logic on ref_clk.
// Notes:   Device events win over a host write landing in the same cycle.
`timescale 1ns/1ps
module wake_bus_ctrl (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Serial port pins
  input  wire logic        spi_csn,
  input  wire logic        spi_sck,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  // Strap pin
  input  wire logic        sw_dev_mode,
  // Device mode events
  input  wire logic        sleep_entry,
  input  wire logic        stop_entry,
  input  wire logic        failsafe_entry,
  input  wire logic        in_failsafe,
  input  wire logic        system_error_flag,
  // Transceiver controls
  output logic [2:0]       can_mode,
  output logic [1:0]       lin_mode,
  output logic [2:0]       lin_ctrl,
  // Wake input controls
  output logic [3:0]       wake_on,
  output logic             sync_input_active,
  output logic             pin2_wake_input,
  output logic [11:0]      wake_filter,
  output logic [7:0]       wake_pull
);
  // ---------------------------------------------------------------
  // Pin synchronisers and frame engine
  // ---------------------------------------------------------------
  logic [3:0]  pin_lvl;
  logic        frame_done;
  logic [31:0] frame;
  logic [15:0] rd_data;
  logic        sdo_w, sdo_oe_w;

  pin_sync #(.WIDTH(4)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin_in  ({sw_dev_mode, spi_sdi, spi_sck, spi_csn}),
    .level   (pin_lvl)
  );

  spi_frame u_frame (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .csn_lvl (pin_lvl[0]),
    .sck_lvl (pin_lvl[1]),
    .sdi_lvl (pin_lvl[2]),
    .rd_data (rd_data),
    .done    (frame_done),
    .frame   (frame),
    .sdo     (sdo_w),
    .sdo_oe  (sdo_oe_w)
  );

  // Frame fields: write flag, address, data
  logic        wr_req;
  logic [6:0]  wr_addr;
  logic [15:0] wd;
  assign wr_req  = frame_done && frame[31];
  assign wr_addr = frame[30:24];
  assign wd      = frame[15:0];

  // ---------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------
  logic [2:0] bank_ff, nxt_bank;
  logic       role_ff, nxt_role;
  logic [2:0] filt_ff [4];
  logic [2:0] nxt_filt [4];
  logic [1:0] pupd_ff [4];
  logic [1:0] nxt_pupd [4];
  logic [1:0] en_ff [4];
  logic [1:0] nxt_en [4];
  logic [2:0] can_ff, nxt_can;
  logic [1:0] lin_ff, nxt_lin;
  logic [2:0] linc_ff, nxt_linc;
  logic [6:0] addr_ff, nxt_addr;
  logic [2:0] boot_ff, nxt_boot;

  // Host writes first, device events after so they win
  always_comb begin
    logic [2:0] nb;
    logic [1:0] bi;
    nb        = bank_ff;
    bi        = 2'h0;
    nxt_bank  = bank_ff;
    nxt_role  = role_ff;
    nxt_filt  = filt_ff;
    nxt_pupd  = pupd_ff;
    nxt_en    = en_ff;
    nxt_can   = can_ff;
    nxt_lin   = lin_ff;
    nxt_linc  = linc_ff;
    nxt_addr  = frame_done ? wr_addr : addr_ff;
    nxt_boot  = boot_ff;
    // Strap caught once the synchroniser has settled after release
    if (boot_ff != wake_bus_pkg::BOOT_DONE) begin
      nxt_boot = boot_ff + 3'h1;
      if (boot_ff == wake_bus_pkg::BOOT_DONE - 3'h1 && pin_lvl[3]) begin
        nxt_can = wake_bus_pkg::CAN_DEV;
        nxt_lin = wake_bus_pkg::LIN_DEV;
      end
    end
    if (wr_req && wr_addr == wake_bus_pkg::BUS_CTRL_ADDR) begin
      nxt_can  = wd[2:0];
      nxt_lin  = wd[wake_bus_pkg::LIN_LSB +: 2];
      nxt_linc = wd[wake_bus_pkg::LINC_LSB +: 3];
    end
    if (wr_req && wr_addr == wake_bus_pkg::WAKE_CTRL_ADDR) begin
      // Reserved bank codes keep the old bank
      if (!wd[2]) begin
        nb = wd[2:0];
      end
      nxt_bank = nb;
      bi       = nb[1:0];
      // Role bit reachable only with bank 2 selected
      if (nb == wake_bus_pkg::BANK_WK2) begin
        nxt_role = wd[wake_bus_pkg::ROLE_POS];
      end
      nxt_pupd[bi] = wd[wake_bus_pkg::PUPD_LSB +: 2];
      nxt_en[bi]   = wd[wake_bus_pkg::EN_LSB +: 2];
      // Sync filter only for input 4 set up as sync input
      if (!wake_bus_pkg::filt_reserved(wd[wake_bus_pkg::FILT_LSB +: 3]) &&
          (wd[wake_bus_pkg::FILT_LSB +: 3] != wake_bus_pkg::FILT_SYNC ||
           (nb == wake_bus_pkg::BANK_WK4 &&
            wd[wake_bus_pkg::EN_LSB +: 2] == wake_bus_pkg::EN_SYNC))) begin
        nxt_filt[bi] = wd[wake_bus_pkg::FILT_LSB +: 3];
      end
    end
    // Sleep: normal without system error, or receive only, go wake
    if (sleep_entry) begin
      if ((can_ff[1:0] == wake_bus_pkg::MODE_NORM && !system_error_flag) ||
          can_ff[1:0] == wake_bus_pkg::MODE_RX) begin
        nxt_can = {can_ff[2], wake_bus_pkg::MODE_WAKE};
      end else begin
        nxt_can = can_ff;
      end
    end else if (stop_entry) begin
      nxt_can = can_ff;
    end
    // Fail-Safe: keep the part wakeable, top CAN bit left alone
    if (failsafe_entry) begin
      nxt_can  = {can_ff[2], wake_bus_pkg::MODE_WAKE};
      nxt_lin  = wake_bus_pkg::MODE_WAKE;
      nxt_linc = 3'h0;
      for (int i = 0; i < 4; i++) begin
        if (!(i == 1 && !nxt_role) &&
            !(i == 3 && en_ff[3] == wake_bus_pkg::EN_SYNC)) begin
          nxt_en[i] = wake_bus_pkg::EN_ON;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bank_ff <= 3'h0;
      role_ff <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        filt_ff[i] <= wake_bus_pkg::FILT_16;
        pupd_ff[i] <= wake_bus_pkg::PUPD_RST;
        en_ff[i]   <= wake_bus_pkg::EN_RST;
      end
      can_ff  <= wake_bus_pkg::CAN_OFF;
      lin_ff  <= 2'h0;
      linc_ff <= 3'h0;
      addr_ff <= 7'h00;
      boot_ff <= 3'h0;
    end else begin
      bank_ff <= nxt_bank;
      role_ff <= nxt_role;
      filt_ff <= nxt_filt;
      pupd_ff <= nxt_pupd;
      en_ff   <= nxt_en;
      can_ff  <= nxt_can;
      lin_ff  <= nxt_lin;
      linc_ff <= nxt_linc;
      addr_ff <= nxt_addr;
      boot_ff <= nxt_boot;
    end
  end

  // ---------------------------------------------------------------
  // Read data, reserved bits forced to zero
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = 16'h0000;
    if (addr_ff == wake_bus_pkg::BUS_CTRL_ADDR) begin
      rd_data = {8'h00, linc_ff, lin_ff, can_ff};
    end else if (addr_ff == wake_bus_pkg::WAKE_CTRL_ADDR) begin
      rd_data = {role_ff && bank_ff == wake_bus_pkg::BANK_WK2, 1'b0,
                 filt_ff[bank_ff[1:0]], pupd_ff[bank_ff[1:0]], 2'h0,
                 en_ff[bank_ff[1:0]], 2'h0, bank_ff};
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [3:0]  on_ff, nxt_on;
  logic        sync_ff, nxt_sync;
  logic [11:0] filt_o_ff, nxt_filt_o;
  logic [7:0]  pull_ff, nxt_pull;

  // One cycle behind the fields, so outputs never glitch
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_on[i] = en_ff[i] == wake_bus_pkg::EN_ON;
      // Fail-Safe ignores the field and uses static 16us sensing
      nxt_filt_o[3*i +: 3] = in_failsafe ? wake_bus_pkg::FILT_16 : filt_ff[i];
      nxt_pull[2*i +: 2]   = pupd_ff[i];
    end
    nxt_sync = en_ff[3] == wake_bus_pkg::EN_SYNC;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      on_ff     <= 4'h0;
      sync_ff   <= 1'b0;
      filt_o_ff <= 12'h000;
      pull_ff   <= 8'h00;
    end else begin
      on_ff     <= nxt_on;
      sync_ff   <= nxt_sync;
      filt_o_ff <= nxt_filt_o;
      pull_ff   <= nxt_pull;
    end
  end

  assign can_mode          = can_ff;
  assign lin_mode          = lin_ff;
  assign lin_ctrl          = linc_ff;
  assign wake_on           = on_ff;
  assign sync_input_active = sync_ff;
  assign pin2_wake_input   = role_ff;
  assign wake_filter       = filt_o_ff;
  assign wake_pull         = pull_ff;
  assign spi_sdo           = sdo_w;
  assign spi_sdo_oe        = sdo_oe_w;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic bus_wr;
  assign bus_wr = wr_req && wr_addr == wake_bus_pkg::BUS_CTRL_ADDR;

  property p_can_msb;
    !bus_wr |=> can_ff[2] == $past(can_ff[2]);
  endproperty
  a_can_msb: assert property (p_can_msb) else $error("can msb changed by device");

  property p_sleep_norm;
    sleep_entry && can_ff[1:0] == 2'h3 && !system_error_flag
      |=> can_mode == {$past(can_ff[2]), 2'h1};
  endproperty
  a_sleep_norm: assert property (p_sleep_norm) else $error("sleep did not set wake");

  property p_sleep_rx;
    sleep_entry && can_ff[1:0] == 2'h2 && !failsafe_entry |=> can_ff == {$past(can_ff[2]), 2'h1};
  endproperty
  a_sleep_rx: assert property (p_sleep_rx) else $error("receive only not woken");

  property p_stop_keep;
    stop_entry && !sleep_entry && !failsafe_entry && !bus_wr &&
      boot_ff == wake_bus_pkg::BOOT_DONE |=> $stable(can_ff);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop changed can mode");

  property p_fs_pattern;
    failsafe_entry |=> lin_mode == 2'h1 && can_mode[1:0] == 2'h1 && lin_ctrl == 3'h0;
  endproperty
  a_fs_pattern: assert property (p_fs_pattern) else $error("fail-safe pattern missing");

  property p_reserved_zero;
    addr_ff == wake_bus_pkg::WAKE_CTRL_ADDR |-> rd_data[14] == 1'b0 &&
      rd_data[8:7] == 2'h0 && rd_data[4:3] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_role_guard;
    wr_req && wr_addr == wake_bus_pkg::WAKE_CTRL_ADDR && wd[2:0] != 3'h1 && !wd[2]
      |=> $stable(role_ff);
  endproperty
  a_role_guard: assert property (p_role_guard) else $error("role written outside bank 2");

  property p_fs_filter;
    in_failsafe [*2] |-> wake_filter == 12'h000;
  endproperty
  a_fs_filter: assert property (p_fs_filter) else $error("filter not static in fail-safe");

  property p_fs_enable;
    failsafe_entry |-> ##2 wake_on[0] && wake_on[2];
  endproperty
  a_fs_enable: assert property (p_fs_enable) else $error("fail-safe enable missing");

  c_sleep: cover property (sleep_entry && can_ff[1:0] == 2'h3 && !system_error_flag);
  c_failsafe: cover property (failsafe_entry ##1 in_failsafe [*3]);
  c_wake_wr: cover property (wr_req && wr_addr == wake_bus_pkg::WAKE_CTRL_ADDR);
  c_sync_on: cover property (sync_input_active && wake_filter[11:9] == 3'h4);
endmodule // wake_bus_ctrl

// file: dv/spi_host.sv
// Purpose: Host model that drives 32-bit register frames into the serial port.
// Assumes: Mode 0, MSB first, ref_clk at 40 MHz.
// Notes:   Six-cycle half periods keep clear of the five-cycle minimum.
`timescale 1ns/1ps
module spi_host (
  // Clock
  input  wire logic ref_clk,
  // Serial port pins
  output logic      spi_csn,
  output logic      spi_sck,
  output logic      spi_sdi,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  localparam int HALF = 6;

  // Idle: deselected, clock parked low
  initial begin
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
  end

  // One whole frame; reply bits taken just before each rising sck
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge ref_clk);
    spi_csn = 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int i = 31; i >= 0; i--) begin
      spi_sdi = tx[i];
      repeat (HALF) @(negedge ref_clk);
      rx[i] = spi_sdo_oe ? spi_sdo : 1'bx;
      spi_sck = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      spi_sck = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    spi_csn = 1'b1;
    spi_sdi = ~spi_sdi; // Released line must not look like held data
    repeat (14) @(negedge ref_clk);
  endtask
endmodule // spi_host

// file: dv/wake_and_bus_mode_control_bench.sv
// Purpose: Self-checking bench for the wake and bus mode control block.
// Assumes: Inputs change on the falling edge of ref_clk.
// Notes:   Reply of a read comes in the frame after the one that names it.
`timescale 1ns/1ps
module wake_and_bus_mode_control_bench;
  typedef struct packed {
    logic [15:0] wdata;
    logic [15:0] rdback;
    logic [15:0] rmask;
    logic [11:0] filt;
    logic [7:0]  pull;
    logic [3:0]  on;
    logic        sync;
    logic        pin2;
  } row_s;

  logic        ref_clk, rstn, spi_csn, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe;
  logic        sw_dev_mode, sleep_entry, stop_entry, failsafe_entry, in_failsafe;
  logic        system_error_flag, sync_input_active, pin2_wake_input;
  logic [2:0]  can_mode, lin_ctrl;
  logic [1:0]  lin_mode;
  logic [3:0]  wake_on;
  logic [11:0] wake_filter;
  logic [7:0]  wake_pull, ev_tab [9];
  logic [15:0] r;
  int          bad_count, total_checks, cycles;
  // Banked writes, each expecting the outputs and readback it leaves behind
  row_s        rows [7] = '{
    '{16'h0a20, 16'h0a20, 16'hffff, 12'h001, 8'h01, 4'hf, 1'b0, 1'b0},
    '{16'hd599, 16'h9401, 16'hffff, 12'h011, 8'h09, 4'hd, 1'b0, 1'b1},
    '{16'h9e62, 16'h1e62, 16'hffff, 12'h0d1, 8'h39, 4'h9, 1'b0, 1'b1},
    '{16'h2243, 16'h2243, 16'hffff, 12'h8d1, 8'h79, 4'h1, 1'b1, 1'b1},
    '{16'h2823, 16'h2023, 16'hffff, 12'h8d1, 8'h39, 4'h9, 1'b0, 1'b1},
    '{16'h2040, 16'h0840, 16'hffff, 12'h8d1, 8'h38, 4'h8, 1'b0, 1'b1},
    '{16'h0024, 16'h0020, 16'hffff, 12'h8d0, 8'h38, 4'h9, 1'b0, 1'b1}};
  // Timer on-time and switch assignment for cyclic rows are kept outside this block

  wake_bus_ctrl wake_bus_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .spi_csn(spi_csn),
    .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .sw_dev_mode(sw_dev_mode), .sleep_entry(sleep_entry), .stop_entry(stop_entry),
    .failsafe_entry(failsafe_entry), .in_failsafe(in_failsafe),
    .system_error_flag(system_error_flag), .can_mode(can_mode), .lin_mode(lin_mode),
    .lin_ctrl(lin_ctrl), .wake_on(wake_on), .sync_input_active(sync_input_active),
    .pin2_wake_input(pin2_wake_input), .wake_filter(wake_filter), .wake_pull(wake_pull));
  spi_host spi_host_inst (.ref_clk(ref_clk), .spi_csn(spi_csn), .spi_sck(spi_sck),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  // ---------------------------------------------------------------
  // Clock, hang guard and reporting
  // ---------------------------------------------------------------
  // Free-running 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Ceiling well above the roughly 25k cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t port got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Register and event helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [31:0] rx;
    spi_host_inst.xfer({1'b1, a, 8'h00, d}, rx);
  endtask

  // Two frames: the second carries the reply to the first
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [31:0] rx;
    spi_host_inst.xfer({1'b0, a, 24'h0}, rx);
    spi_host_inst.xfer({1'b0, a, 24'h0}, rx);
    d = rx[15:0];
  endtask

  // One-cycle mode entry pulse {sleep, stop, failsafe}, then let outputs settle
  task automatic ev(input logic [2:0] e);
    {sleep_entry, stop_entry, failsafe_entry} = e;
    @(negedge ref_clk);
    {sleep_entry, stop_entry, failsafe_entry} = 3'h0;
    repeat (3) @(negedge ref_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Rows: {start code, stop not sleep, system error, expected code}
  initial begin
    ev_tab = '{8'h61, 8'he5, 8'h41, 8'h52, 8'h6b, 8'h21, 8'h00, 8'h94, 8'h31};
    {rstn, sw_dev_mode, sleep_entry, stop_entry, failsafe_entry} = 5'h0;
    {in_failsafe, system_error_flag} = 2'h0;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk_out(wake_on, 12'hf);
    chk_out(can_mode, 12'h0);
    chk_out(lin_mode, 12'h0);
    rd(wake_bus_pkg::WAKE_CTRL_ADDR, r);
    chk_reg(r, 16'h0020);
    rd(wake_bus_pkg::BUS_CTRL_ADDR, r);
    chk_reg(r, 16'h0000);
    rd(7'h7f, r);
    chk_reg(r, 16'h0000);
    $display("test reset_values done");
    foreach (rows[i]) begin
      wr(wake_bus_pkg::WAKE_CTRL_ADDR, rows[i].wdata);
      chk_out(wake_filter, rows[i].filt);
      chk_out(wake_pull, rows[i].pull);
      chk_out(wake_on, rows[i].on);
      chk_out(sync_input_active, rows[i].sync);
      chk_out(pin2_wake_input, rows[i].pin2);
      rd(wake_bus_pkg::WAKE_CTRL_ADDR, r);
      chk_reg(r & rows[i].rmask, rows[i].rdback);
      $display("test wake_row %0d done", i);
    end
    foreach (ev_tab[i]) begin
      system_error_flag = ev_tab[i][3];
      wr(wake_bus_pkg::BUS_CTRL_ADDR, {11'h0, 2'h3, ev_tab[i][7:5]});
      ev(ev_tab[i][4] ? 3'h2 : 3'h4);
      chk_out(can_mode, ev_tab[i][2:0]);
      chk_out(lin_mode, 12'h3);
      rd(wake_bus_pkg::BUS_CTRL_ADDR, r);
      chk_reg(r, {11'h0, 2'h3, ev_tab[i][2:0]});
      $display("test can_event %0d done", i);
    end
    system_error_flag = 1'b0;
    wr(wake_bus_pkg::WAKE_CTRL_ADDR, 16'h0001);
    wr(wake_bus_pkg::WAKE_CTRL_ADDR, 16'h0043);
    wr(wake_bus_pkg::BUS_CTRL_ADDR, 16'h00fe);
    in_failsafe = 1'b1;
    ev(3'h1);
    chk_out(can_mode, 12'h5);
    chk_out(lin_mode, 12'h1);
    chk_out(lin_ctrl, 12'h0);
    chk_out(wake_on, 12'h5);
    chk_out(sync_input_active, 12'h1);
    chk_out(wake_filter, 12'h000);
    rd(wake_bus_pkg::BUS_CTRL_ADDR, r);
    chk_reg(r, 16'h000d);
    in_failsafe = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_out(wake_filter, 12'h0c0);
    $display("test failsafe done");
    // Mid-run reset with the development strap high
    rstn = 1'b0;
    sw_dev_mode = 1'b1;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_out(can_mode, 12'h1);
    chk_out(lin_mode, 12'h3);
    rd(wake_bus_pkg::WAKE_CTRL_ADDR, r);
    chk_reg(r, 16'h0020);
    $display("test dev_mode_reset done");
    print_verdict();
  end
endmodule // wake_and_bus_mode_control_bench
